// ===== logic/adc_back_end_pkg.sv
// constants, register indices and helper functions for the converter back-end register bank
package adc_back_end_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int SAMPLE_W = 16;
  localparam int DECIM_W = 9;
  localparam int STAGES_W = 4;
  localparam int DELAY_W = 3;
  localparam int CYCLES_W = 4;
  localparam int FRAC_LATENCY = 59;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PLL_OUT = 8'h6d;
  localparam logic [7:0] IDX_PAT_A_LO = 8'h74;
  localparam logic [7:0] IDX_PAT_A_HI = 8'h75;
  localparam logic [7:0] IDX_PAT_B_LO = 8'h76;
  localparam logic [7:0] IDX_PAT_B_HI = 8'h77;
  localparam logic [7:0] IDX_POSTPROC = 8'h79;
  localparam logic [7:0] IDX_FRAC = 8'h7a;
  localparam logic [7:0] IDX_DECIM_A = 8'h7b;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] PLL_UNUSED_MASK = 8'hc0;
  localparam int PLL_CLK_EN_BIT = 5;
  localparam int DELAY_LSB = 1;
  localparam int POSTPROC_EN_BIT = 7;
  localparam int FIRST_DECIM_BIT = 6;
  localparam int FRAC_EN_BIT = 5;

  // vco delay per code; codes 0 to 7 give 0, 1, 5, 7, 9, 11, 14 and 15 cycles
  localparam logic [7:0][3:0] VCO_DELAY_TABLE = {4'hf, 4'he, 4'hb, 4'h9, 4'h7, 4'h5, 4'h1, 4'h0};

  function automatic logic is_thermo(input logic [DECIM_W-1:0] x);
    return (x & (x + 9'h001)) == 9'h000;
  endfunction

  function automatic logic [STAGES_W-1:0] popcount(input logic [DECIM_W-1:0] x);
    logic [STAGES_W-1:0] n;
    n = 4'h0;
    for (int i = 0; i < DECIM_W; i++) begin
      n = n + {3'h0, x[i]};
    end
    return n;
  endfunction

  function automatic logic [DECIM_W-1:0] stage_mask(input logic [STAGES_W-1:0] s);
    return (9'h001 << s) - 9'h001;
  endfunction
endpackage

// ===== logic/decim_if.sv
// decimation select and decoded stage controls between the bank and its decoder
`timescale 1ns/1ps
`default_nettype none
interface decim_if;
  logic [adc_back_end_pkg::DECIM_W-1:0] select;
  logic single_mode;
  logic dual_mode;
  logic [adc_back_end_pkg::DECIM_W-1:0] stage_en;
  logic [adc_back_end_pkg::STAGES_W-1:0] stages;
  logic code_error;
  modport ctrl (output select, output single_mode, output dual_mode,
                input stage_en, input stages, input code_error);
  modport chain (input select, input single_mode, input dual_mode,
                 output stage_en, output stages, output code_error);
endinterface
`default_nettype wire

// ===== logic/decim_chain_a_decode.sv
// decoder of the thermometer-coded decimation select
`timescale 1ns/1ps
`default_nettype none
module decim_chain_a_decode (
  decim_if.chain dif
);
  logic ok_single;
  logic ok_dual;

  // single mode wins when both modes are raised; a non-thermometer code disables the chain
  always_comb begin
    ok_single = dif.single_mode && dif.select[0] && adc_back_end_pkg::is_thermo(dif.select);
    ok_dual = !dif.single_mode && dif.dual_mode && !dif.select[0]
              && adc_back_end_pkg::is_thermo(dif.select >> 1);
    dif.stage_en = (ok_single || ok_dual) ? dif.select : 9'h000;
    dif.stages = adc_back_end_pkg::popcount(dif.stage_en);
    dif.code_error = (dif.select != 9'h000) && !(ok_single || ok_dual);
  end
endmodule // decim_chain_a_decode
`default_nettype wire

// ===== logic/frac_delay_line.sv
// fixed-latency delay line used for fractional delay recovery
`timescale 1ns/1ps
`default_nettype none
module frac_delay_line (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic in_valid,
  input wire logic [adc_back_end_pkg::SAMPLE_W-1:0] in_data,
  output logic out_valid,
  output logic [adc_back_end_pkg::SAMPLE_W-1:0] out_data
);
  logic [adc_back_end_pkg::SAMPLE_W:0] line_reg [adc_back_end_pkg::FRAC_LATENCY];
  logic [6:0] en_cnt_reg;

  // the line always shifts so toggling enable only swaps the tap, no refill stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < adc_back_end_pkg::FRAC_LATENCY; i++) begin
        line_reg[i] <= 17'h0_0000;
      end
    end else begin
      line_reg[0] <= {in_valid, in_data};
      for (int i = 1; i < adc_back_end_pkg::FRAC_LATENCY; i++) begin
        line_reg[i] <= line_reg[i-1];
      end
    end
  end

  // output stage: one cycle when off, 59 more when on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= 16'h0000;
    end else if (enable) begin
      {out_valid, out_data} <= line_reg[adc_back_end_pkg::FRAC_LATENCY-1];
    end else begin
      out_valid <= in_valid;
      out_data <= in_data;
    end
  end

  // helper: cycles enable has been steady high, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_cnt_reg <= 7'h00;
    end else if (!enable) begin
      en_cnt_reg <= 7'h00;
    end else if (en_cnt_reg != 7'h7f) begin
      en_cnt_reg <= en_cnt_reg + 7'h01;
    end
  end

  frac_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en_cnt_reg > 7'h3c) |-> (out_valid == $past(in_valid, 60) && out_data == $past(in_data, 60)))
    else $error("delay line latency is not 59 extra cycles");
endmodule // frac_delay_line
`default_nettype wire

// ===== logic/adc_clock_pattern_decim_regs.sv
// apb register bank for pll output clock, test patterns, post-processing and decimation
`timescale 1ns/1ps
`default_nettype none
// Operation
// - pll clock enable bit routes the pll clock to the core; off at reset
// - three-bit code sets output clock delay in vco cycles, 0 to 15
// - pll output register acts only with pll selected and pll enabled
// - vco delay applies only with pll source and no decimation
// - pattern a is low byte at one index, high byte at the next
// - pattern b is low byte at one index, high byte at the next
// - top bit of post-processing register enables dual-channel post-processing
// - bit 6 of the fractional register enables first decimation stage
// - fractional delay recovery enable adds 59 cycles of latency
// - fractional and decimation settings act only in single or dual mode
// - single mode: thermometer code from bit 0, up to decimate by 512
// - dual mode: thermometer code from bit 1, bit 0 clear, up to 256
// - all-zero select disables every decimation stage; reset state
// - each enabled stage halves the output data rate
// - top two bits of pll output register read as zero
module adc_clock_pattern_decim_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_back_end_pkg::ADDR_W-1:0] paddr,
  input wire logic [adc_back_end_pkg::DATA_W-1:0] pwdata,
  output logic [adc_back_end_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_source_is_pll,
  input wire logic pll_enable,
  input wire logic single_channel_mode,
  input wire logic dual_channel_mode,
  input wire logic sample_valid,
  input wire logic [adc_back_end_pkg::SAMPLE_W-1:0] sample_data,
  output logic pll_clk_to_core_enable,
  output logic [adc_back_end_pkg::CYCLES_W-1:0] out_clock_delay_cycles,
  output logic [adc_back_end_pkg::SAMPLE_W-1:0] pattern_a,
  output logic [adc_back_end_pkg::SAMPLE_W-1:0] pattern_b,
  output logic dual_postproc_enable,
  output logic frac_delay_recovery_active,
  output logic [adc_back_end_pkg::DECIM_W-1:0] decim_stage_enable,
  output logic [adc_back_end_pkg::STAGES_W-1:0] decim_stages,
  output logic decim_code_error,
  output logic out_valid,
  output logic [adc_back_end_pkg::SAMPLE_W-1:0] out_data
);
  logic [7:0] pll_out_reg;
  logic [7:0] pat_a_lo_reg;
  logic [7:0] pat_a_hi_reg;
  logic [7:0] pat_b_lo_reg;
  logic [7:0] pat_b_hi_reg;
  logic [7:0] postproc_reg;
  logic [7:0] frac_reg;
  logic [7:0] decim_hi_reg;
  logic [adc_back_end_pkg::DATA_W-1:0] rdata_reg;
  logic err_reg;
  logic [adc_back_end_pkg::DECIM_W-1:0] rate_cnt_reg;
  logic [7:0] index;
  logic addr_ok;
  logic setup;
  logic access;
  logic wr_en;
  logic pll_active;
  logic mode_ok;
  logic keep_valid;
  logic [adc_back_end_pkg::DECIM_W-1:0] mask;

  decim_if dif ();

  function automatic logic reg_mapped(input logic [7:0] idx);
    return idx == adc_back_end_pkg::IDX_PLL_OUT || idx == adc_back_end_pkg::IDX_PAT_A_LO
        || idx == adc_back_end_pkg::IDX_PAT_A_HI || idx == adc_back_end_pkg::IDX_PAT_B_LO
        || idx == adc_back_end_pkg::IDX_PAT_B_HI || idx == adc_back_end_pkg::IDX_POSTPROC
        || idx == adc_back_end_pkg::IDX_FRAC || idx == adc_back_end_pkg::IDX_DECIM_A;
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      adc_back_end_pkg::IDX_PLL_OUT: v = pll_out_reg & ~adc_back_end_pkg::PLL_UNUSED_MASK;
      adc_back_end_pkg::IDX_PAT_A_LO: v = pat_a_lo_reg;
      adc_back_end_pkg::IDX_PAT_A_HI: v = pat_a_hi_reg;
      adc_back_end_pkg::IDX_PAT_B_LO: v = pat_b_lo_reg;
      adc_back_end_pkg::IDX_PAT_B_HI: v = pat_b_hi_reg;
      adc_back_end_pkg::IDX_POSTPROC: v = postproc_reg;
      adc_back_end_pkg::IDX_FRAC: v = frac_reg;
      adc_back_end_pkg::IDX_DECIM_A: v = decim_hi_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // address decode: word aligned, index in bits 9:2, top bits must be zero
  assign index = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && reg_mapped(index);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_en = access && pwrite && addr_ok;

  // zero wait states: the answer is ready in every access cycle
  assign pready = access;
  assign pslverr = access && err_reg;
  assign prdata = rdata_reg;

  // read data and error are captured in setup, registers cannot change before access ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg <= {24'h00_0000, (addr_ok && !pwrite) ? read_byte(index) : 8'h00};
      err_reg <= !addr_ok;
    end
  end

  // configuration writes; factory bits are stored like any other bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_out_reg <= adc_back_end_pkg::RESET_BYTE;
      pat_a_lo_reg <= adc_back_end_pkg::RESET_BYTE;
      pat_a_hi_reg <= adc_back_end_pkg::RESET_BYTE;
      pat_b_lo_reg <= adc_back_end_pkg::RESET_BYTE;
      pat_b_hi_reg <= adc_back_end_pkg::RESET_BYTE;
      postproc_reg <= adc_back_end_pkg::RESET_BYTE;
      frac_reg <= adc_back_end_pkg::RESET_BYTE;
      decim_hi_reg <= adc_back_end_pkg::RESET_BYTE;
    end else if (wr_en) begin
      case (index)
        adc_back_end_pkg::IDX_PLL_OUT: pll_out_reg <= pwdata[7:0] & ~adc_back_end_pkg::PLL_UNUSED_MASK;
        adc_back_end_pkg::IDX_PAT_A_LO: pat_a_lo_reg <= pwdata[7:0];
        adc_back_end_pkg::IDX_PAT_A_HI: pat_a_hi_reg <= pwdata[7:0];
        adc_back_end_pkg::IDX_PAT_B_LO: pat_b_lo_reg <= pwdata[7:0];
        adc_back_end_pkg::IDX_PAT_B_HI: pat_b_hi_reg <= pwdata[7:0];
        adc_back_end_pkg::IDX_POSTPROC: postproc_reg <= pwdata[7:0];
        adc_back_end_pkg::IDX_FRAC: frac_reg <= pwdata[7:0];
        adc_back_end_pkg::IDX_DECIM_A: decim_hi_reg <= pwdata[7:0];
        default: pll_out_reg <= pll_out_reg;
      endcase
    end
  end

  // patterns come straight from the byte registers, low byte at the lower index
  assign pattern_a = {pat_a_hi_reg, pat_a_lo_reg};
  assign pattern_b = {pat_b_hi_reg, pat_b_lo_reg};

  // decimation select spans two registers: bit 0 sits in the fractional register
  assign mode_ok = single_channel_mode || dual_channel_mode;
  assign dif.select = {decim_hi_reg, frac_reg[adc_back_end_pkg::FIRST_DECIM_BIT]};
  assign dif.single_mode = single_channel_mode;
  assign dif.dual_mode = dual_channel_mode;

  decim_chain_a_decode decoder (
    .dif(dif.chain)
  );

  // pll controls act only while the pll is both the selected source and running
  assign pll_active = clk_source_is_pll && pll_enable;

  // control outputs registered so downstream clock logic never sees decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_clk_to_core_enable <= 1'b0;
      out_clock_delay_cycles <= 4'h0;
      dual_postproc_enable <= 1'b0;
      frac_delay_recovery_active <= 1'b0;
      decim_stage_enable <= 9'h000;
      decim_stages <= 4'h0;
      decim_code_error <= 1'b0;
    end else begin
      pll_clk_to_core_enable <= pll_active && pll_out_reg[adc_back_end_pkg::PLL_CLK_EN_BIT];
      out_clock_delay_cycles <= (pll_active && dif.stages == 4'h0)
          ? adc_back_end_pkg::VCO_DELAY_TABLE[pll_out_reg[adc_back_end_pkg::DELAY_LSB +: adc_back_end_pkg::DELAY_W]]
          : 4'h0;
      dual_postproc_enable <= postproc_reg[adc_back_end_pkg::POSTPROC_EN_BIT];
      frac_delay_recovery_active <= mode_ok && frac_reg[adc_back_end_pkg::FRAC_EN_BIT];
      decim_stage_enable <= dif.stage_en;
      decim_stages <= dif.stages;
      decim_code_error <= dif.code_error;
    end
  end

  // rate reduction keeps one sample in 2^stages; real filtering is outside this block
  assign mask = adc_back_end_pkg::stage_mask(decim_stages);
  assign keep_valid = sample_valid && ((rate_cnt_reg & mask) == mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_cnt_reg <= 9'h000;
    end else if (decim_stages == 4'h0) begin
      rate_cnt_reg <= 9'h000;
    end else if (sample_valid) begin
      rate_cnt_reg <= rate_cnt_reg + 9'h001;
    end
  end

  frac_delay_line delay_line (
    .pclk(pclk),
    .presetn(presetn),
    .enable(frac_delay_recovery_active),
    .in_valid(keep_valid),
    .in_data(sample_data),
    .out_valid(out_valid),
    .out_data(out_data)
  );

  // properties run on the bus clock and stay quiet while reset is held
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus phases as the slave sees them, by register index
  sequence wr_idx(logic [7:0] idx);
    psel && penable && pwrite && paddr == {2'h0, idx, 2'h0};
  endsequence

  sequence rd_setup(logic [7:0] idx);
    psel && !penable && !pwrite && paddr == {2'h0, idx, 2'h0};
  endsequence

  pll_clk_gate_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_PLL_OUT) ##1 pll_active [*2]
    |-> pll_clk_to_core_enable == $past(pwdata[adc_back_end_pkg::PLL_CLK_EN_BIT], 2))
    else $error("pll clock enable does not follow written bit");

  pll_gate_src_a: assert property (
    !pll_active |=> !pll_clk_to_core_enable && out_clock_delay_cycles == 4'h0)
    else $error("pll controls acted without pll source");

  delay_code_a: assert property (
    pll_active && dif.stages == 4'h0
      && pll_out_reg[adc_back_end_pkg::DELAY_LSB +: adc_back_end_pkg::DELAY_W] == 3'h7
    |=> out_clock_delay_cycles == 4'hf)
    else $error("delay code seven is not fifteen cycles");

  delay_no_decim_a: assert property (
    decim_stages != 4'h0 |-> out_clock_delay_cycles == 4'h0 || $past(dif.stages) == 4'h0)
    else $error("vco delay applied during decimation");

  unused_zero_a: assert property (
    rd_setup(adc_back_end_pkg::IDX_PLL_OUT) |=> prdata[7:6] == 2'h0)
    else $error("pll register top bits not zero");

  pattern_a_join_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_PAT_A_HI) ##1 1'b1 |-> pattern_a[15:8] == $past(pwdata[7:0]))
    else $error("pattern a upper byte not joined");

  pattern_b_join_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_PAT_B_LO) |=> pattern_b[7:0] == $past(pwdata[7:0])
      && $stable(pattern_b[15:8]))
    else $error("pattern b lower byte not joined");

  postproc_bit_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_POSTPROC) |-> ##2 dual_postproc_enable == $past(pwdata[7], 2))
    else $error("dual post-processing enable not applied");

  first_stage_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_FRAC) |=> dif.select[0] == $past(pwdata[6]))
    else $error("first decimation bit not taken");

  mode_gate_a: assert property (
    !mode_ok |=> decim_stage_enable == 9'h000 && !frac_delay_recovery_active)
    else $error("decimation active outside single and dual modes");

  single_thermo_a: assert property (
    single_channel_mode && dif.select == 9'h1ff |=> decim_stages == 4'h9 && !decim_code_error)
    else $error("single mode full chain not nine stages");

  dual_thermo_a: assert property (
    !single_channel_mode && dual_channel_mode && dif.select[0] |=> decim_stages == 4'h0
      && decim_code_error)
    else $error("dual mode accepted first stage bit");

  zero_select_a: assert property (
    dif.select == 9'h000 |=> decim_stage_enable == 9'h000 && !decim_code_error)
    else $error("zero select left a stage on");

  rate_halve_a: assert property (
    keep_valid && decim_stages == 4'h1 ##1 sample_valid && decim_stages == 4'h1 |-> !keep_valid)
    else $error("one stage did not halve the rate");

  field_readback_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_DECIM_A) ##1 !psel ##1 rd_setup(adc_back_end_pkg::IDX_DECIM_A)
    |=> prdata[7:0] == $past(pwdata[7:0], 3))
    else $error("register did not read back the written value");

  // refused transfers: bad address seen in setup, answered in access
  sequence bad_setup;
    psel && !penable && !addr_ok;
  endsequence

  error_response_a: assert property (
    bad_setup ##1 psel && penable |-> pslverr && pready)
    else $error("refused address not flagged");

  refused_write_a: assert property (
    psel && penable && pwrite && !addr_ok |=> $stable(pll_out_reg) && $stable(frac_reg)
      && $stable(decim_hi_reg) && $stable(postproc_reg))
    else $error("refused write changed a register");

  pattern_a_low_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_PAT_A_LO) |=> pattern_a[7:0] == $past(pwdata[7:0])
      && $stable(pattern_a[15:8]))
    else $error("pattern a lower byte not joined");

  pattern_b_high_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_PAT_B_HI) |=> pattern_b[15:8] == $past(pwdata[7:0]))
    else $error("pattern b upper byte not joined");

  frac_enable_a: assert property (
    wr_idx(adc_back_end_pkg::IDX_FRAC) ##1 mode_ok [*2]
    |-> frac_delay_recovery_active == $past(pwdata[adc_back_end_pkg::FRAC_EN_BIT], 2))
    else $error("fractional recovery enable not applied");

  single_first_bit_a: assert property (
    single_channel_mode && !dif.select[0] && dif.select != 9'h000
    |=> decim_stages == 4'h0 && decim_code_error)
    else $error("single mode accepted a chain without stage one");

  dual_full_chain_a: assert property (
    !single_channel_mode && dual_channel_mode && dif.select == 9'h1fe
    |=> decim_stages == 4'h8 && !decim_code_error)
    else $error("dual mode full chain not eight stages");

  delay_one_code_a: assert property (
    pll_active && dif.stages == 4'h0
      && pll_out_reg[adc_back_end_pkg::DELAY_LSB +: adc_back_end_pkg::DELAY_W] == 3'h1
    |=> out_clock_delay_cycles == 4'h1)
    else $error("delay code one is not one cycle");

  pll_top_clear_a: assert property (
    (pll_out_reg & adc_back_end_pkg::PLL_UNUSED_MASK) == 8'h00)
    else $error("pll register holds bits in its unused top");
endmodule // adc_clock_pattern_decim_regs
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the converter back-end register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic src = 1'b0;
  logic pen = 1'b0;
  logic sgl = 1'b0;
  logic dul = 1'b0;
  logic sv = 1'b0;
  logic [15:0] sd = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, ck_en, pp_en, frac_on, cerr, ov, er;
  logic [15:0] pa, pb, od;
  logic [3:0] dly, nst;
  logic [8:0] sten;
  logic [31:0] rd;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] mdl [int];
  int exp_t [$];
  logic [15:0] exp_d [$];
  // register indices and the bits that software may change (factory bits stay 0)
  logic [7:0] ix [8] = '{8'h6d, 8'h74, 8'h75, 8'h76, 8'h77, 8'h79, 8'h7a, 8'h7b};
  logic [7:0] mk [8] = '{8'hee, 8'hff, 8'hff, 8'hff, 8'hff, 8'h80, 8'h60, 8'hff};
  int tbl [8] = '{0, 1, 5, 7, 9, 11, 14, 15};

  adc_clock_pattern_decim_regs u_adc_clock_pattern_decim_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_source_is_pll(src), .pll_enable(pen), .single_channel_mode(sgl),
    .dual_channel_mode(dul), .sample_valid(sv), .sample_data(sd),
    .pll_clk_to_core_enable(ck_en), .out_clock_delay_cycles(dly), .pattern_a(pa),
    .pattern_b(pb), .dual_postproc_enable(pp_en), .frac_delay_recovery_active(frac_on),
    .decim_stage_enable(sten), .decim_stages(nst), .decim_code_error(cerr),
    .out_valid(ov), .out_data(od)
  );

  always #2.5 pclk = ~pclk;
  // cycle count kept on the falling edge so posedge drivers read it race free
  always @(negedge pclk) begin
    cyc <= cyc + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
    mdl[i] = (i == 8'h6d) ? (d & 8'h3f) : d;
  endtask

  task automatic rreg(input logic [7:0] i);
    apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    chk(rd, {24'h00_0000, mdl[i]});
    chk(er, 1'b0);
  endtask

  task automatic wdec(input logic [8:0] c, input logic f);
    wreg(8'h7a, {1'b0, c[0], f, 5'h00});
    wreg(8'h7b, c[8:1]);
  endtask

  // let registered outputs settle, then compare every control and pattern output with the model, the code error only in single or dual mode
  task automatic chk_out;
    logic [8:0] s;
    logic ok;
    logic act;
    int n;
    repeat (3) @(posedge pclk);
    #1;
    s = {mdl[8'h7b], mdl[8'h7a][6]};
    act = src & pen;
    ok = 1'b0;
    n = 0;
    if (sgl) begin
      ok = (s & (s + 9'h001)) == 9'h000;
    end else if (dul) begin
      ok = !s[0] && (((s >> 1) & ((s >> 1) + 9'h001)) == 9'h000);
    end
    if (ok) begin
      n = $countones(s);
    end
    chk(nst, n);
    chk(sten, ok ? s : 9'h000);
    if (sgl || dul) begin
      chk(cerr, s != 9'h000 && !ok);
    end
    chk(ck_en, act & mdl[8'h6d][5]);
    chk(dly, (act && n == 0) ? tbl[mdl[8'h6d][3:1]] : 0);
    chk(pa, {mdl[8'h75], mdl[8'h74]});
    chk(pb, {mdl[8'h77], mdl[8'h76]});
    chk(pp_en, mdl[8'h79][7]);
    chk(frac_on, mdl[8'h7a][5] & (sgl | dul));
  endtask

  // sixteen samples back to back; stage counter is cleared by passing through zero stages
  task automatic stream(input logic [8:0] c, input logic f);
    int k;
    int m;
    int lat;
    logic [15:0] d;
    wdec(9'h000, 1'b0);
    chk_out;
    wdec(c, f);
    chk_out;
    m = (1 << $countones(c)) - 1;
    lat = f ? 60 : 1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      d = 16'($urandom);
      sv <= 1'b1;
      sd <= d;
      if ((k & m) == m) begin
        exp_t.push_back(cyc + lat);
        exp_d.push_back(d);
      end
    end
    @(posedge pclk);
    sv <= 1'b0;
    repeat (80) @(posedge pclk);
    chk(exp_t.size(), 0);
  endtask

  // output stream monitor: order, data and arrival cycle
  always @(negedge pclk) begin
    if (ov === 1'b1) begin
      if (exp_t.size() == 0) begin
        chk(1'b1, 1'b0);
      end else begin
        chk(cyc, exp_t.pop_front());
        chk(od, exp_d.pop_front());
      end
    end
  end

  initial begin
    void'($urandom(32'h7085));
    foreach (ix[i]) mdl[ix[i]] = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ix[i]) rreg(ix[i]);
    chk_out;
    // random contents, upper pll bits written as ones to see them read zero;
    // resolution is taken as 16 bits here, so no low pattern bit is unused
    foreach (ix[i]) wreg(ix[i], 8'($urandom) & mk[i] | (i == 0 ? 8'hc0 : 8'h00));
    rreg(8'h7b);
    foreach (ix[i]) rreg(ix[i]);
    chk_out;
    // pll gating and every delay code
    wdec(9'h000, 1'b0);
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge pclk);
        src <= g[0];
        pen <= g[1];
        wreg(8'h6d, 8'hc0 | 8'(c << 1) | (c[1] ? 8'h20 : 8'h00));
        chk_out;
      end
    end
    // every stage count in both modes, then an illegal code; both modes high means single
    wreg(8'h79, 8'h80);
    for (int md = 0; md < 2; md++) begin
      @(posedge pclk);
      sgl <= (md == 0);
      dul <= 1'b1;
      for (int n = 0; n < 10; n++) begin
        wdec(md == 0 ? 9'((1 << n) - 1) : 9'(((1 << n) - 1) << 1), n[0]);
        chk_out;
      end
      wdec(md == 0 ? 9'h005 : 9'h003, 1'b0);
      chk_out;
    end
    @(posedge pclk);
    sgl <= 1'b0;
    dul <= 1'b0;
    wdec(9'h003, 1'b1);
    chk_out;
    @(posedge pclk);
    sgl <= 1'b1;
    stream(9'h000, 1'b0);
    stream(9'h003, 1'b0);
    stream(9'h001, 1'b1);
    @(posedge pclk);
    sgl <= 1'b0;
    dul <= 1'b1;
    stream(9'h006, 1'b0);
    // unmapped and misaligned places are refused and change nothing
    apb(1'b1, 12'h1c0, 8'h5a);
    chk(er, 1'b1);
    apb(1'b0, 12'h1c0, 8'h00);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h1b5, 8'h5a);
    chk(er, 1'b1);
    rreg(8'h6d);
    // second reset in mid-run restores every field
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ix[i]) mdl[ix[i]] = 8'h00;
    foreach (ix[i]) rreg(ix[i]);
    chk_out;
    give_verdict;
  end

  // hang guard, well beyond the roughly 1050 cycles the sequence needs
  initial begin
    #400_000;
    err_total++;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
